// ### include/scu_pkg.sv
// Constants shared by the smart-card serial channel design.
// Assumes an APB master with 32-bit data; one register per aligned word.
// -----------------------------------------------------------------
// Functional notes
// -----------------------------------------------------------------
// Functional notes
// - Internal clock: bit rate is prescaled clock over sixteen times divisor plus one.
// - External clock: bit rate is clock pin frequency over sixteen times divisor plus one.
// - Two-bit count source picks prescaler of one, two, eight or thirty-two.
// - Transmit starts only with transmit enabled and buffer holding data.
// - Receive starts only with receive enabled and a start bit seen.
// - Transmit interrupt fires when shift register finishes, if source select set.
// - Receive interrupt fires when a frame moves into the receive buffer.
// - Overrun flagged when new frame nears its stop bit before buffer was read.
// - On overrun, buffer data is undefined and receive interrupt is left alone.
// - Framing error flagged when the stop bit is missing.
// - Receive parity mismatch pulls the transmit pin low toward the card.
// - Error summary reads one when any overrun, framing or parity flag set.
// - Setting source select and error enable after reset gives a spurious transmit request.
// - Readable flags for shift empty, buffer empty and receive complete.
// - Parity error signal is driven only with the error signal enable set.
// - Reading receive buffer during error signal clears parity flag and releases pin.
// - Transmit finished request comes at the clock falling edge after the stop bit.
package scu_pkg;
  // -----------------------------------------------------------------
  // Register offsets
  // -----------------------------------------------------------------
  localparam logic [7:0] ADDR_TXBUF = 8'h00;
  localparam logic [7:0] ADDR_RXBUF = 8'h04;
  localparam logic [7:0] ADDR_BAUD = 8'h08;
  localparam logic [7:0] ADDR_MODE = 8'h0C;
  localparam logic [7:0] ADDR_CTL0 = 8'h10;
  localparam logic [7:0] ADDR_CTL1 = 8'h14;
  localparam logic [7:0] ADDR_SMR1 = 8'h18;
  localparam logic [7:0] ADDR_SMR2 = 8'h1C;
  localparam logic [7:0] ADDR_SMR3 = 8'h20;
  localparam logic [7:0] ADDR_SMR4 = 8'h24;
  localparam logic [7:0] ADDR_IRQ = 8'h28;
  // -----------------------------------------------------------------
  // Field positions
  // -----------------------------------------------------------------
  localparam int MODE_CLKSRC = 3;
  localparam int MODE_STOP = 4;
  localparam int MODE_PODD = 5;
  localparam int MODE_PEN = 6;
  localparam int CTL0_SHEMPTY = 3;
  localparam int CTL0_ORDER = 7;
  localparam int CTL1_TXEN = 0;
  localparam int CTL1_TXEMPTY = 1;
  localparam int CTL1_RXEN = 2;
  localparam int CTL1_RXDONE = 3;
  localparam int CTL1_IRQSRC = 4;
  localparam int CTL1_INV = 6;
  localparam int CTL1_ERREN = 7;
  localparam int RXB_OVR = 12;
  localparam int RXB_FRM = 13;
  localparam int RXB_PAR = 14;
  localparam int RXB_SUM = 15;
  localparam int IRQ_TX = 0;
  localparam int IRQ_RX = 1;
  // -----------------------------------------------------------------
  // Reset values and timing
  // -----------------------------------------------------------------
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_CTL0 = 8'h08;
  localparam logic [7:0] RST_CTL1 = 8'h02;
  localparam logic [7:0] RST_BAUD = 8'h00;
  localparam int OVERSAMPLE = 16;
  localparam int MID_SAMPLE = 8;
  localparam int FRAME_BITS = 11;
endpackage

// ### design/scu_uart.sv
// Smart-card mode of an asynchronous serial channel with APB registers.
// Assumes an external pull-up on the joined open-drain data line.
`timescale 1ns/1ps
`default_nettype none
module scu_uart
  import scu_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serialInPin,
  input wire logic serialClockPin,
  output logic serialOutPin,
  output logic serialOutEn,
  output logic txIrq,
  output logic rxIrq
);
  // -----------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------
  function automatic logic [7:0] revBits(input logic [7:0] v);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7 - i];
    end
    return r;
  endfunction

  // -----------------------------------------------------------------
  // Pin synchronisers
  // -----------------------------------------------------------------
  logic [1:0] rxSync_q;
  logic [1:0] ckSync_q;
  logic ckPrev_q;
  always_ff @(posedge mclk) begin
    if (rst) begin
      rxSync_q <= 2'h3;
      ckSync_q <= 2'h0;
      ckPrev_q <= 1'b0;
    end else begin
      rxSync_q <= {rxSync_q[0], serialInPin};
      ckSync_q <= {ckSync_q[0], serialClockPin};
      ckPrev_q <= ckSync_q[1];
    end
  end
  wire logic rxLine = rxSync_q[1];

  // -----------------------------------------------------------------
  // Registers
  // -----------------------------------------------------------------
  logic [7:0] mode_q, ctl0_q, ctl1_q, baud_q, txBuf_q;
  logic [7:0] smr1_q, smr2_q, smr3_q, smr4_q;
  logic txEmpty_q, rxDone_q, shEmpty_q;
  logic [8:0] rxBuf_q;
  logic ovr_q, frm_q, par_q;
  logic txIrqReq_q, rxIrqReq_q;
  wire logic apbWr = psel & penable & pwrite;
  wire logic apbRd = psel & penable & ~pwrite;
  wire logic inverse = ctl1_q[CTL1_INV];
  wire logic msbFirst = ctl0_q[CTL0_ORDER];
  logic txLoad, rxStore, txFinish, txSetIrq, rxOvr, rxFrm, rxPar;
  logic [7:0] rxData;

  always_ff @(posedge mclk) begin
    if (rst) begin
      mode_q <= RST_MODE;
      ctl0_q <= RST_CTL0;
      ctl1_q <= RST_CTL1;
      baud_q <= RST_BAUD;
      txBuf_q <= 8'h00;
      smr1_q <= 8'h00;
      smr2_q <= 8'h00;
      smr3_q <= 8'h00;
      smr4_q <= 8'h00;
    end else if (apbWr) begin
      if (paddr == ADDR_TXBUF) begin
        txBuf_q <= pwdata[7:0];
      end else if (paddr == ADDR_BAUD) begin
        baud_q <= pwdata[7:0];
      end else if (paddr == ADDR_MODE) begin
        mode_q <= pwdata[7:0];
      end else if (paddr == ADDR_CTL0) begin
        ctl0_q <= {pwdata[7:4], 1'b0, pwdata[2:0]};
      end else if (paddr == ADDR_CTL1) begin
        ctl1_q <= {pwdata[7:4], 1'b0, pwdata[2], 1'b0, pwdata[0]};
      end else if (paddr == ADDR_SMR1) begin
        smr1_q <= pwdata[7:0];
      end else if (paddr == ADDR_SMR2) begin
        smr2_q <= pwdata[7:0];
      end else if (paddr == ADDR_SMR3) begin
        smr3_q <= pwdata[7:0];
      end else if (paddr == ADDR_SMR4) begin
        smr4_q <= pwdata[7:0];
      end
    end
  end

  // Status flags: hardware set wins over software clear, except a transmit buffer write beats the load setting buffer empty
  wire logic rxRead = apbRd && paddr == ADDR_RXBUF;
  wire logic irqWr = apbWr && paddr == ADDR_IRQ;
  always_ff @(posedge mclk) begin
    if (rst) begin
      txEmpty_q <= 1'b1;
      rxDone_q <= 1'b0;
      rxBuf_q <= 9'h000;
      ovr_q <= 1'b0;
      frm_q <= 1'b0;
      par_q <= 1'b0;
    end else begin
      if (apbWr && paddr == ADDR_TXBUF) begin
        txEmpty_q <= 1'b0;
      end else if (txLoad) begin
        txEmpty_q <= 1'b1;
      end
      if (rxStore) begin
        rxDone_q <= 1'b1;
        rxBuf_q <= {1'b0, rxData};
        frm_q <= rxFrm;
        par_q <= rxPar;
        ovr_q <= rxDone_q;
      end else if (rxRead) begin
        rxDone_q <= 1'b0;
        par_q <= 1'b0;
        frm_q <= 1'b0;
        ovr_q <= 1'b0;
      end
      if (rxOvr) begin
        ovr_q <= 1'b1;
      end
    end
  end

  // Irq request flags, cleared by writing one
  always_ff @(posedge mclk) begin
    if (rst) begin
      txIrqReq_q <= 1'b0;
      rxIrqReq_q <= 1'b0;
    end else begin
      if (txSetIrq) begin
        txIrqReq_q <= 1'b1;
      end else if (irqWr && pwdata[IRQ_TX]) begin
        txIrqReq_q <= 1'b0;
      end
      if (rxStore && !rxDone_q) begin
        rxIrqReq_q <= 1'b1;
      end else if (irqWr && pwdata[IRQ_RX]) begin
        rxIrqReq_q <= 1'b0;
      end
    end
  end

  // Spurious request when source select and error enable become both set
  logic irqSrcPrev_q;
  always_ff @(posedge mclk) begin
    if (rst) begin
      irqSrcPrev_q <= 1'b0;
    end else begin
      irqSrcPrev_q <= ctl1_q[CTL1_IRQSRC] & ctl1_q[CTL1_ERREN];
    end
  end

  // -----------------------------------------------------------------
  // Baud generator
  // -----------------------------------------------------------------
  logic [4:0] pre_q;
  logic [7:0] brg_q;
  logic preTick, tick_q;
  always_comb begin
    case (ctl0_q[1:0])
      2'h0: preTick = 1'b1;
      2'h1: preTick = pre_q[0];
      2'h2: preTick = &pre_q[2:0];
      default: preTick = &pre_q;
    endcase
    if (mode_q[MODE_CLKSRC]) begin
      preTick = ckSync_q[1] & ~ckPrev_q;
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      pre_q <= 5'h00;
      brg_q <= 8'h00;
      tick_q <= 1'b0;
    end else begin
      pre_q <= pre_q + 5'h01;
      tick_q <= 1'b0;
      if (preTick) begin
        if (brg_q == 8'h00) begin
          brg_q <= baud_q;
          tick_q <= 1'b1;
        end else begin
          brg_q <= brg_q - 8'h01;
        end
      end
    end
  end

  // -----------------------------------------------------------------
  // Transmitter
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {ScuTxIdle, ScuTxShift, ScuTxTail} scu_tx_t;
  scu_tx_t txState_q;
  logic [10:0] txShift_q;
  logic [3:0] txSub_q, txBit_q;
  logic [7:0] txOrd;
  logic txPar;
  always_comb begin
    txOrd = msbFirst ? revBits(txBuf_q) : txBuf_q;
    txPar = (^txBuf_q) ^ ~mode_q[MODE_PODD];
    if (inverse) begin
      txOrd = ~txOrd;
      txPar = ~txPar;
    end
  end
  assign txLoad = txState_q == ScuTxIdle && ctl1_q[CTL1_TXEN] && !txEmpty_q;
  assign txFinish = txState_q == ScuTxTail && tick_q && txSub_q == 4'(MID_SAMPLE - 1);
  assign txSetIrq = (txFinish && ctl1_q[CTL1_IRQSRC])
    || (txLoad && !ctl1_q[CTL1_IRQSRC])
    || ((ctl1_q[CTL1_IRQSRC] & ctl1_q[CTL1_ERREN]) && !irqSrcPrev_q);
  always_ff @(posedge mclk) begin
    if (rst) begin
      txState_q <= ScuTxIdle;
      txShift_q <= 11'h7FF;
      txSub_q <= 4'h0;
      txBit_q <= 4'h0;
      shEmpty_q <= 1'b1;
    end else begin
      case (txState_q)
        ScuTxIdle: begin
          if (txLoad) begin
            txShift_q <= {1'b1, ~mode_q[MODE_PEN] | txPar, txOrd, 1'b0};
            txState_q <= ScuTxShift;
            shEmpty_q <= 1'b0;
            txSub_q <= 4'h0;
            txBit_q <= 4'h0;
          end
        end
        ScuTxShift: begin
          if (tick_q) begin
            txSub_q <= txSub_q + 4'h1;
            if (txSub_q == 4'(OVERSAMPLE - 1)) begin
              txShift_q <= {1'b1, txShift_q[10:1]};
              txBit_q <= txBit_q + 4'h1;
              if (txBit_q == 4'(FRAME_BITS - 1)) begin
                txState_q <= ScuTxTail;
              end
            end
          end
        end
        ScuTxTail: begin
          if (txFinish) begin
            txState_q <= ScuTxIdle;
            shEmpty_q <= 1'b1;
          end else if (tick_q) begin
            txSub_q <= txSub_q + 4'h1;
          end
        end
        default: txState_q <= ScuTxIdle;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // Receiver
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {ScuRxIdle, ScuRxFrame, ScuRxErr} scu_rx_t;
  scu_rx_t rxState_q;
  logic [3:0] rxSub_q, rxBit_q;
  logic [9:0] rxShift_q;
  logic errDrive_q;
  logic [8:0] rxRaw;
  logic rxStop;
  wire logic rxSample = rxState_q == ScuRxFrame && tick_q && rxSub_q == 4'(MID_SAMPLE - 1);
  always_comb begin
    rxRaw = inverse ? ~rxShift_q[9:1] : rxShift_q[9:1];
    rxData = msbFirst ? revBits(rxRaw[7:0]) : rxRaw[7:0];
    rxPar = mode_q[MODE_PEN] && ((^rxData) ^ rxRaw[8] ^ ~mode_q[MODE_PODD]);
    rxStop = rxLine;
    rxFrm = !rxStop;
  end
  assign rxStore = rxSample && rxBit_q == 4'(FRAME_BITS - 1);
  assign rxOvr = rxSample && rxBit_q == 4'(FRAME_BITS - 2) && rxDone_q;
  always_ff @(posedge mclk) begin
    if (rst) begin
      rxState_q <= ScuRxIdle;
      rxSub_q <= 4'h0;
      rxBit_q <= 4'h0;
      rxShift_q <= 10'h000;
      errDrive_q <= 1'b0;
    end else begin
      case (rxState_q)
        ScuRxIdle: begin
          if (ctl1_q[CTL1_RXEN] && !rxLine) begin
            rxState_q <= ScuRxFrame;
            rxSub_q <= 4'h0;
            rxBit_q <= 4'h0;
          end
        end
        ScuRxFrame: begin
          if (tick_q) begin
            rxSub_q <= rxSub_q + 4'h1;
          end
          if (rxSample) begin
            rxBit_q <= rxBit_q + 4'h1;
            if (rxBit_q == 4'h0 && rxLine) begin
              rxState_q <= ScuRxIdle;
            end else if (rxBit_q < 4'(FRAME_BITS - 1)) begin
              rxShift_q <= {rxLine, rxShift_q[9:1]};
            end else if (rxPar && ctl1_q[CTL1_ERREN]) begin
              rxState_q <= ScuRxErr;
              errDrive_q <= 1'b1;
            end else begin
              rxState_q <= ScuRxIdle;
            end
          end
        end
        ScuRxErr: begin
          if (rxRead || !ctl1_q[CTL1_ERREN]) begin
            errDrive_q <= 1'b0;
            rxState_q <= ScuRxIdle;
          end
        end
        default: rxState_q <= ScuRxIdle;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // Pins, interrupts and read data
  // -----------------------------------------------------------------
  logic [31:0] rdMux;
  always_comb begin
    rdMux = 32'h0000_0000;
    if (paddr == ADDR_RXBUF) begin
      rdMux = {16'h0000, ovr_q | frm_q | par_q, par_q, frm_q, ovr_q, 3'h0, rxBuf_q};
    end else if (paddr == ADDR_MODE) begin
      rdMux = {24'h000000, mode_q};
    end else if (paddr == ADDR_CTL0) begin
      rdMux = {24'h000000, ctl0_q[7:4], shEmpty_q, ctl0_q[2:0]};
    end else if (paddr == ADDR_CTL1) begin
      rdMux = {24'h000000, ctl1_q[7:4], rxDone_q, ctl1_q[2], txEmpty_q, ctl1_q[0]};
    end else if (paddr == ADDR_SMR1) begin
      rdMux = {24'h000000, smr1_q};
    end else if (paddr == ADDR_SMR2) begin
      rdMux = {24'h000000, smr2_q};
    end else if (paddr == ADDR_SMR3) begin
      rdMux = {24'h000000, smr3_q};
    end else if (paddr == ADDR_SMR4) begin
      rdMux = {24'h000000, smr4_q};
    end else if (paddr == ADDR_IRQ) begin
      rdMux = {30'h0, rxIrqReq_q, txIrqReq_q};
    end
  end
  wire logic mapped = paddr <= ADDR_IRQ && paddr[1:0] == 2'h0;
  always_ff @(posedge mclk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata <= rdMux;
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      serialOutPin <= 1'b1;
      serialOutEn <= 1'b0;
      txIrq <= 1'b0;
      rxIrq <= 1'b0;
    end else begin
      serialOutPin <= 1'b0;
      serialOutEn <= errDrive_q | !txShift_q[0];
      txIrq <= txIrqReq_q;
      rxIrq <= rxIrqReq_q;
    end
  end
endmodule
`default_nettype wire

// ### test/scu_uart_assertions.sv
// Port checker for the smart-card serial channel.
// Assumes binding to scu_uart; watches its ports only.
`timescale 1ns/1ps
`default_nettype none
module scu_uart_chk
  import scu_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic serialOutPin,
  input wire logic serialOutEn,
  input wire logic txIrq,
  input wire logic rxIrq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic rdRx;
  logic clrIrq;
  assign rdRx = pready && !pwrite && paddr == ADDR_RXBUF;
  assign clrIrq = pready && pwrite && paddr == ADDR_IRQ;
  property p_ack; psel && !penable |=> pready; endproperty
  a_ack: assert property (p_ack) else $error("no zero-wait answer");
  property p_cause; pready |-> $past(psel) && !$past(penable); endproperty
  a_cause: assert property (p_cause) else $error("answer without setup");
  property p_err; psel && !penable && paddr > 8'h28 |=> pready && pslverr; endproperty
  a_err: assert property (p_err) else $error("unmapped access taken");
  property p_sum; rdRx |-> prdata[RXB_SUM] == (|prdata[RXB_PAR:RXB_OVR]); endproperty
  a_sum: assert property (p_sum) else $error("summary flag wrong");
  property p_rel; rdRx && prdata[RXB_PAR] && serialOutEn |-> ##[1:2] !serialOutEn; endproperty
  a_rel: assert property (p_rel) else $error("error signal kept");
  property p_low; serialOutEn |-> !serialOutPin; endproperty
  a_low: assert property (p_low) else $error("line not pulled low");
  property p_clrtx; clrIrq && pwdata[IRQ_TX] |=> ##1 !txIrq; endproperty
  a_clrtx: assert property (p_clrtx) else $error("tx request not cleared");
  property p_clrrx; clrIrq && pwdata[IRQ_RX] |=> ##1 !rxIrq; endproperty
  a_clrrx: assert property (p_clrrx) else $error("rx request not cleared");
  property p_rst; $fell(rst) |-> !txIrq && !rxIrq && !serialOutEn && !pready; endproperty
  a_rst: assert property (p_rst) else $error("outputs active after reset");
  c_rx: cover property ($rose(rxIrq));
  c_tx: cover property ($rose(txIrq));
  c_perr: cover property (rdRx && prdata[RXB_PAR]);
endmodule
bind scu_uart scu_uart_chk u_scu_uart_chk (.mclk(mclk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .serialOutPin(serialOutPin),
  .serialOutEn(serialOutEn), .txIrq(txIrq), .rxIrq(rxIrq));
`default_nettype wire

// ### test/scu_card_model.sv
// Smart-card model on the shared open-drain data line.
// Assumes a pull-up; bit time in mclk cycles is set by the bench.
`timescale 1ns/1ps
`default_nettype none
module scu_card_model (
  input wire logic mclk,
  input wire logic lineLvl,
  output logic cardLow
);
  int bitCyc = 16;
  initial cardLow = 1'b0;
  // Bits in line order, even parity on line levels, three guard bits
  task automatic send(input logic [7:0] b, input logic badPar);
    logic [12:0] f;
    f = {3'h7, ^b ^ badPar, b, 1'b0};
    for (int i = 0; i < 13; i++) begin
      cardLow <= !f[i];
      repeat (bitCyc) @(posedge mclk);
    end
  endtask
  // Bounded hunt for a start bit, then mid-bit sampling
  task automatic recv(output logic [7:0] b, output logic pOk);
    logic [8:0] s;
    int n;
    n = 0;
    while (lineLvl !== 1'b0 && n < 20000) begin
      @(posedge mclk);
      n++;
    end
    repeat (bitCyc / 2) @(posedge mclk);
    for (int i = 0; i < 9; i++) begin
      repeat (bitCyc) @(posedge mclk);
      s[i] = lineLvl;
    end
    b = s[7:0];
    pOk = s[8] === ^s[7:0];
    repeat (bitCyc) @(posedge mclk);
  endtask
endmodule
`default_nettype wire

// ### test/test_smart_card_uart_mode.sv
// Self-checking bench for the smart-card serial channel.
// Assumes the card model and a pull-up on the joined data line.
`timescale 1ns/1ps
`default_nettype none
module test_smart_card_uart_mode import scu_pkg::*;;
  logic mclk, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, lastErr;
  logic pready, pslverr, serialOutPin, serialOutEn, txIrq, rxIrq, cardLow;
  logic [1:0] extCnt = 2'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  int errCount = 0, nChecks = 0;
  int cyc[5] = '{16, 32, 128, 1024, 64};
  wire lineLvl;
  // Pull-up: low only while a party pulls it
  assign lineLvl = !(serialOutEn && !serialOutPin) && !cardLow;
  scu_uart u_scu_uart (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serialInPin(lineLvl), .serialClockPin(extCnt[1]),
    .serialOutPin(serialOutPin), .serialOutEn(serialOutEn), .txIrq(txIrq), .rxIrq(rxIrq));
  scu_card_model u_scu_card_model (.mclk(mclk), .lineLvl(lineLvl), .cardLow(cardLow));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // Free-running external clock, four mclk cycles a period
  always @(posedge mclk) extCnt <= extCnt + 2'h1;
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    nChecks++;
    if (g !== e) begin
      errCount++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic endOfTest();
    $display("checks %0d mismatches %0d", nChecks, errCount);
    if (errCount == 0 && nChecks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic waitHi(input logic rx);
    int n;
    n = 0;
    while ((rx ? rxIrq : txIrq) !== 1'b1 && n < 4096) begin
      @(posedge mclk);
      n++;
    end
    chk(32'(n < 4096), 32'h1, "irq timeout");
    if (n >= 4096) endOfTest();
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    chk(32'(n < 64), 32'h1, "bus timeout");
    if (n >= 64) endOfTest();
    r = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [7:0] enc(input logic [7:0] d, input logic inv);
    logic [7:0] v;
    for (int i = 0; i < 8; i++) begin
      v[i] = d[7 - i];
    end
    return inv ? ~v : d;
  endfunction
  task automatic cfg(input logic inv, input logic src, input logic [1:0] fld,
                     input logic [7:0] baud, input int c, input logic een);
    apb(1'b1, ADDR_BAUD, {24'h0, baud}, rd);
    apb(1'b1, ADDR_MODE, {25'h0, 1'b1, !inv, 1'b0, src, 3'h0}, rd);
    apb(1'b1, ADDR_CTL0, {24'h0, inv, 5'h0, fld}, rd);
    apb(1'b1, ADDR_CTL1, {24'h0, een, inv, 6'h15}, rd);
    apb(1'b1, ADDR_IRQ, 32'h3, rd);
    u_scu_card_model.bitCyc = c;
  endtask
  task automatic t_regs();
    apb(1'b0, ADDR_CTL0, 32'h0, rd);
    chk(rd, {24'h0, RST_CTL0}, "ctl0 reset");
    apb(1'b0, ADDR_CTL1, 32'h0, rd);
    chk(rd, {24'h0, RST_CTL1}, "ctl1 reset");
    apb(1'b0, 8'h2C, 32'h0, rd);
    chk(32'(lastErr), 32'h1, "unmapped");
    $display("regs done");
  endtask
  task automatic t_tx(input logic [7:0] d, input logic inv);
    logic [7:0] b;
    logic p;
    chk(32'(lineLvl), 32'h1, "idle");
    fork
      u_scu_card_model.recv(b, p);
      begin
        apb(1'b1, ADDR_TXBUF, {24'h0, d}, rd);
        repeat (8) @(posedge mclk);
        chk(32'(txIrq), 32'h0, "early tx irq");
      end
    join
    chk({24'h0, b}, {24'h0, enc(d, inv)}, "tx data");
    chk(32'(p), 32'h1, "tx parity");
    waitHi(1'b0);
    chk(32'(lineLvl), 32'h1, "card error");
    // Joined line: own frame comes back as an echo
    apb(1'b0, ADDR_RXBUF, 32'h0, rd);
    chk(rd & 32'hF0FF, {24'h0, d}, "echo");
    apb(1'b1, ADDR_IRQ, 32'h3, rd);
    $display("tx done");
  endtask
  task automatic t_rx(input logic [7:0] d, input logic inv, input logic bad, input logic een);
    u_scu_card_model.send(enc(d, inv), bad);
    waitHi(1'b1);
    chk(32'(serialOutEn), 32'(bad & een), "error signal");
    apb(1'b0, ADDR_RXBUF, 32'h0, rd);
    chk(rd & 32'hF0FF, {16'h0, (bad ? 4'hC : 4'h0), 4'h0, d}, "rx buffer");
    // Release shows two edges later: state flop, then pin flop
    repeat (2) @(posedge mclk);
    chk(32'(serialOutEn), 32'h0, "error release");
    apb(1'b1, ADDR_IRQ, 32'h2, rd);
    $display("rx done");
  endtask
  task automatic t_ovr();
    u_scu_card_model.send(8'h11, 1'b0);
    waitHi(1'b1);
    apb(1'b1, ADDR_IRQ, 32'h2, rd);
    u_scu_card_model.send(8'h22, 1'b0);
    chk(32'(rxIrq), 32'h0, "irq kept");
    apb(1'b0, ADDR_RXBUF, 32'h0, rd);
    chk(rd & 32'hF000, 32'h9000, "overrun");
    apb(1'b1, ADDR_CTL1, 32'h91, rd);
    u_scu_card_model.send(8'h33, 1'b0);
    chk(32'(rxIrq), 32'h0, "rx while off");
    $display("overrun done");
  endtask
  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    t_regs();
    // Four prescaler steps, the last with a larger divisor, then the external clock
    for (int i = 0; i < 5; i++) begin
      cfg(1'b0, i == 4, 2'(i), 8'(i == 3), cyc[i], 1'b1);
      t_tx(8'hA5 ^ 8'(i), 1'b0);
    end
    cfg(1'b1, 1'b0, 2'h0, 8'h00, 16, 1'b1);
    t_tx(8'h3B, 1'b1);
    t_rx(8'h3B, 1'b1, 1'b0, 1'b1);
    t_rx(8'h3B, 1'b1, 1'b1, 1'b1);
    cfg(1'b0, 1'b0, 2'h0, 8'h00, 16, 1'b1);
    t_rx(8'h5C, 1'b0, 1'b0, 1'b1);
    t_rx(8'h5C, 1'b0, 1'b1, 1'b1);
    cfg(1'b0, 1'b0, 2'h0, 8'h00, 16, 1'b0);
    t_rx(8'h5C, 1'b0, 1'b1, 1'b0);
    t_ovr();
    endOfTest();
  end
endmodule
`default_nettype wire
